// [pkg/ibs_defines.vh]
// register map, field positions and timing constants of the inband signalling block
`ifndef IBS_DEFINES_VH
`define IBS_DEFINES_VH

// timing
`define IBS_CLK_HZ      50000000
`define IBS_BAUD        1200
`define IBS_PLL_SHIFT   6

// register byte addresses (low eight address bits)
`define IBS_A_MODE      8'h00
`define IBS_A_CFG       8'h04
`define IBS_A_TT        8'h08
`define IBS_A_ATONE     8'h0c
`define IBS_A_TSTAT     8'h10
`define IBS_A_STAT      8'h14
`define IBS_A_RXD       8'h18
`define IBS_A_SYNC      8'h1c
`define IBS_A_TXD       8'h20
`define IBS_A_RST       8'h24

// reset values
`define IBS_SYNC_RST    16'hcb23

// mode control fields
`define IBS_MC_EN       2
`define IBS_MC_SRC      4
`define IBS_MC_IB       11:8
`define IBS_IB_DTMF_RX  8
`define IBS_IB_DTMF_TX  9
`define IBS_IB_TONE     10

// modem configuration fields
`define IBS_CF_SYNC     15
`define IBS_CF_SEL      11
`define IBS_CF_RAW      10
`define IBS_CF_AUX_HI   8:3
`define IBS_CF_AUX_LO   1:0

// tone pair register fields
`define IBS_TT_KEY      3:0
`define IBS_TT_SINGLE   4
`define IBS_TT_TWIST    5

// status fields
`define IBS_TS_DTMF     10
`define IBS_ST_RDY      0
`define IBS_ST_FSYNC    1
`define IBS_ST_SYNC     3
`define IBS_ST_DTMF     12

// tone frequencies in hz
`define IBS_F_L0        12'd697
`define IBS_F_L1        12'd770
`define IBS_F_L2        12'd852
`define IBS_F_L3        12'd941
`define IBS_F_H0        12'd1209
`define IBS_F_H1        12'd1336
`define IBS_F_H2        12'd1477
`define IBS_F_H3        12'd1633
`define IBS_F_MARK      12'd1300
`define IBS_F_SPACE     12'd2100
`define IBS_TONE_MIN    12'd288
`define IBS_TONE_MAX    12'd3000
`define IBS_HPF_KNEE    12'd400

// selective-call symbols and framing
`define IBS_DX_PH       7'd125
`define IBS_RX_PH_LO    7'd104
`define IBS_RX_PH_HI    7'd111
`define IBS_CHAR_LAST   4'd9
`define IBS_WORD_LAST   4'hf
`define IBS_TX_LEN_RAW  5'd16
`define IBS_TX_LEN_FMT  5'd20

`endif

// [verilog/ibs_bit_pll.v]
// bit clock recovery for the fsk receiver
`timescale 1ns/1ps
`include "ibs_defines.vh"
module ibs_bit_pll #(
  parameter PERIOD = 41666
) (
  // clock and reset
  input  wire i_clock,
  input  wire i_reset_n,
  // control
  input  wire i_enable,
  input  wire i_narrow,
  // sliced data in, recovered bits out
  input  wire i_data,
  output reg  o_strobe,
  output reg  o_bit
);
  localparam CW = $clog2(PERIOD);
  localparam [31:0]   P32  = PERIOD;
  localparam [CW-1:0] LAST = P32[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
  localparam [CW-1:0] HALF = P32[CW:1];
  localparam [31:0]   S32  = P32 >> `IBS_PLL_SHIFT;
  localparam [CW-1:0] STEP = S32[CW-1:0];

  reg [CW-1:0] cnt_reg;
  reg          prev_reg;

  wire edge_w = i_data ^ prev_reg;

  // wide mode snaps to each edge; narrow mode only nudges, so noise edges barely move it
  always @(posedge i_clock) begin
    if (!i_reset_n || !i_enable) begin
      cnt_reg  <= {CW{1'b0}};
      prev_reg <= 1'b0;
      o_strobe <= 1'b0;
      o_bit    <= 1'b0;
    end else begin
      prev_reg <= i_data;
      o_strobe <= (cnt_reg == HALF);
      if (cnt_reg == HALF) begin
        o_bit <= i_data;
      end
      if (edge_w && !i_narrow) begin
        cnt_reg <= {CW{1'b0}};
      end else if (edge_w && cnt_reg < HALF) begin
        cnt_reg <= (cnt_reg > STEP) ? cnt_reg - STEP : {CW{1'b0}};
      end else if (edge_w) begin
        cnt_reg <= (LAST - cnt_reg > STEP) ? cnt_reg + STEP : LAST;
      end else begin
        cnt_reg <= (cnt_reg == LAST) ? {CW{1'b0}} : cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [verilog/ibs_modem.v]
// inband signalling top: dtmf and tone control, 1200 bit/s selective-call modem
// Notes on behaviour
// - audio tone programmable 288 to 3000 Hz
// - mode field bits 11-8 selects inband mode
// - dtmf detect sets tone b10, status b12
// - new dtmf code overwrites held tone value
// - hex tone code maps to dtmf pair
// - twist lowers low tone by 2 dB
// - single tone: high for 8-F, else low
// - fsk 1300 one, 2100 zero, pre-emphasis
// - select bit 11, start/stop bit 2
// - selective call ignores config bits 8-3, 1-0
// - symbols sent as ten-bit checked patterns
// - pll clock, 16-bit words, overwrite unread
// - match programmable sync word, flag it
// - search stops after match until re-enable
// - raw mode delivers bits unaligned, or words after the sync match with sync option
// - formatted mode waits for phasing sequence
// - two characters per word, flags 15, 7
// - pll narrows after phasing found
// - pick error-free diversity copy
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ibs_defines.vh"
module ibs_modem #(
  parameter BIT_CYCLES = `IBS_CLK_HZ / `IBS_BAUD
) (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_reset_n,
  // ahb-lite slave
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  // dtmf detector result
  input  wire        i_dtmf_valid,
  input  wire [3:0]  i_dtmf_code,
  // hard-limited discriminator data
  input  wire        i_rx_data,
  // tone generator control
  output reg  [11:0] o_tone_lo_hz,
  output reg  [11:0] o_tone_hi_hz,
  output reg         o_tone_lo_on,
  output reg         o_tone_hi_on,
  output reg         o_tone_lo_cut_2db,
  output reg         o_hpf_bypass,
  output reg  [3:0]  o_inband_mode,
  // fsk modulator control
  output reg         o_tx_on,
  output reg  [11:0] o_tx_tone_hz,
  output reg         o_tx_preemph,
  output reg         o_tx_bit,
  output reg  [7:0]  o_cfg_aux
);

  localparam CW = $clog2(BIT_CYCLES);
  localparam [31:0]   BC32     = BIT_CYCLES;
  localparam [CW-1:0] BIT_LAST = BC32[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

  // host registers
  reg  [15:0]   mode_reg;
  reg  [15:0]   cfg_reg;
  reg  [15:0]   tx_tone_pair_reg;
  reg  [11:0]   atone_reg;
  reg  [15:0]   tstat_reg;
  reg  [15:0]   status_reg;
  reg  [15:0]   rxd_reg;
  reg  [15:0]   sync_reg;
  reg  [15:0]   txd_reg;

  // bus state
  reg           soft_rst_reg;
  reg           wr_pend_reg;
  reg  [7:0]    wa_reg;
  reg  [31:0]   rdat;

  // receive state
  reg           en_d_reg;
  reg           search_reg;
  reg           phased_reg;
  reg           rxslot_reg;
  reg           half_reg;
  reg  [3:0]    rcnt_reg;
  reg  [3:0]    slot_reg;
  reg  [7:0]    ch1_reg;
  reg  [59:0]   sr_reg;

  // transmit state
  reg  [CW-1:0] tcnt_reg;
  reg  [19:0]   tx_sh_reg;
  reg  [4:0]    tx_left_reg;

  function [9:0] sym_enc;
    input [6:0] v;
    reg   [2:0] z;
    integer     i;
    begin
      z = 3'd0;
      for (i = 0; i < 7; i = i + 1) begin
        z = z + {2'b00, ~v[i]};
      end
      sym_enc = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], z};
    end
  endfunction

  // bit 1 on air sits in c[9]
  function [6:0] sym_val;
    input [9:0] c;
    sym_val = {c[3], c[4], c[5], c[6], c[7], c[8], c[9]};
  endfunction

  function sym_ok;
    input [9:0] c;
    sym_ok = (sym_enc(sym_val(c)) == c);
  endfunction

  function is_rxph;
    input [9:0] c;
    reg   [6:0] v;
    begin
      v = sym_val(c);
      is_rxph = sym_ok(c) && (v >= `IBS_RX_PH_LO) && (v <= `IBS_RX_PH_HI);
    end
  endfunction

  function is_dx;
    input [9:0] c;
    is_dx = sym_ok(c) && (sym_val(c) == `IBS_DX_PH);
  endfunction

  function [11:0] dtmf_lo;
    input [3:0] k;
    case (k)
      4'h1, 4'h2, 4'h3, 4'hd: dtmf_lo = `IBS_F_L0;
      4'h4, 4'h5, 4'h6, 4'he: dtmf_lo = `IBS_F_L1;
      4'h7, 4'h8, 4'h9, 4'hf: dtmf_lo = `IBS_F_L2;
      default:                dtmf_lo = `IBS_F_L3;
    endcase
  endfunction

  function [11:0] dtmf_hi;
    input [3:0] k;
    case (k)
      4'h1, 4'h4, 4'h7, 4'hb: dtmf_hi = `IBS_F_H0;
      4'h2, 4'h5, 4'h8, 4'ha: dtmf_hi = `IBS_F_H1;
      4'h3, 4'h6, 4'h9, 4'hc: dtmf_hi = `IBS_F_H2;
      default:                dtmf_hi = `IBS_F_H3;
    endcase
  endfunction

  function [11:0] tone_clamp;
    input [11:0] f;
    begin
      if (f < `IBS_TONE_MIN) begin
        tone_clamp = `IBS_TONE_MIN;
      end else if (f > `IBS_TONE_MAX) begin
        tone_clamp = `IBS_TONE_MAX;
      end else begin
        tone_clamp = f;
      end
    end
  endfunction

  // soft reset presets everything, bus handshake included
  wire rst = ~i_reset_n | soft_rst_reg;

  wire       ap = i_hsel & i_htrans[1] & i_hready;
  wire       rd = ap & ~i_hwrite;
  wire [7:0] ra = i_haddr[7:0];

  wire sel    = cfg_reg[`IBS_CF_SEL];
  wire raw    = cfg_reg[`IBS_CF_RAW];
  wire syn_on = cfg_reg[`IBS_CF_SYNC];
  wire en     = mode_reg[`IBS_MC_EN] & sel;
  wire rx_en  = en & ~mode_reg[`IBS_MC_SRC];
  wire tx_en  = en & mode_reg[`IBS_MC_SRC];

  wire bit_stb;
  wire bit_val;

  ibs_bit_pll #(
    .PERIOD (BIT_CYCLES)
  ) u_pll (
    .i_clock   (i_clock),
    .i_reset_n (~rst),
    .i_enable  (rx_en),
    .i_narrow  (phased_reg),
    .i_data    (i_rx_data),
    .o_strobe  (bit_stb),
    .o_bit     (bit_val)
  );

  // window including the bit arriving now; c0 is the newest character
  wire [59:0] nsr   = {sr_reg[58:0], bit_val};
  wire [15:0] rword = nsr[15:0];
  wire [9:0]  c0    = nsr[9:0];
  wire [9:0]  c1    = nsr[19:10];
  wire [9:0]  c2    = nsr[29:20];
  wire [9:0]  c3    = nsr[39:30];
  wire [9:0]  c4    = nsr[49:40];
  wire [9:0]  c5    = nsr[59:50];

  wire [2:0] nrx = {2'b00, is_rxph(c0)} + {2'b00, is_rxph(c2)} + {2'b00, is_rxph(c4)};
  wire [2:0] nph = nrx + {2'b00, is_dx(c1)} + {2'b00, is_dx(c3)};
  wire       phase_hit = (nph >= 3'd3) && (nrx != 3'd0);

  // c5 is the dx copy of the rx character c0
  wire       ok_r = sym_ok(c0);
  wire       ok_d = sym_ok(c5);
  wire [7:0] pick = ok_r ? {1'b0, sym_val(c0)} : ok_d ? {1'b0, sym_val(c5)} : {1'b1, sym_val(c0)};

  wire        tick    = (tcnt_reg == BIT_LAST);
  wire [4:0]  tx_len  = raw ? `IBS_TX_LEN_RAW : `IBS_TX_LEN_FMT;
  wire [19:0] tx_load = raw ? {txd_reg, 4'h0} : {sym_enc(txd_reg[14:8]), sym_enc(txd_reg[6:0])};

  wire        tone_md = mode_reg[`IBS_IB_TONE];
  wire        dtmf_tx = mode_reg[`IBS_IB_DTMF_TX];
  wire [3:0]  key     = tx_tone_pair_reg[`IBS_TT_KEY];
  wire        single  = tx_tone_pair_reg[`IBS_TT_SINGLE];
  wire [11:0] atone_c = tone_clamp(atone_reg);

  always @* begin
    case (ra)
      `IBS_A_MODE:  rdat = {16'h0000, mode_reg};
      `IBS_A_CFG:   rdat = {16'h0000, cfg_reg};
      `IBS_A_TT:    rdat = {16'h0000, tx_tone_pair_reg};
      `IBS_A_ATONE: rdat = {20'h00000, atone_reg};
      `IBS_A_TSTAT: rdat = {16'h0000, tstat_reg};
      `IBS_A_STAT:  rdat = {16'h0000, status_reg};
      `IBS_A_RXD:   rdat = {16'h0000, rxd_reg};
      `IBS_A_SYNC:  rdat = {16'h0000, sync_reg};
      `IBS_A_TXD:   rdat = {16'h0000, txd_reg};
      default:      rdat = 32'h00000000;
    endcase
  end

  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_pend_reg && (wa_reg == `IBS_A_RST);
    end
  end

  // zero wait states: reads answer in the data phase, writes land at its end
  always @(posedge i_clock) begin
    if (rst) begin
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend_reg <= 1'b0;
      wa_reg      <= 8'h00;
    end else begin
      wr_pend_reg <= ap & i_hwrite;
      wa_reg      <= ra;
      if (rd) begin
        o_hrdata <= rdat;
      end
    end
  end

  // register file and receiver; later assignments win, so hardware sets beat read clears
  always @(posedge i_clock) begin
    if (rst) begin
      mode_reg         <= 16'h0000;
      cfg_reg          <= 16'h0000;
      tx_tone_pair_reg <= 16'h0000;
      atone_reg        <= 12'h000;
      tstat_reg        <= 16'h0000;
      status_reg       <= 16'h0000;
      rxd_reg          <= 16'h0000;
      sync_reg         <= `IBS_SYNC_RST;
      txd_reg          <= 16'h0000;
      en_d_reg         <= 1'b0;
      search_reg       <= 1'b0;
      phased_reg       <= 1'b0;
      rxslot_reg       <= 1'b0;
      half_reg         <= 1'b0;
      rcnt_reg         <= 4'h0;
      slot_reg         <= 4'h0;
      ch1_reg          <= 8'h00;
      sr_reg           <= 60'h0;
    end else begin
      if (wr_pend_reg) begin
        case (wa_reg)
          `IBS_A_MODE:  mode_reg <= i_hwdata[15:0];
          `IBS_A_CFG:   cfg_reg <= i_hwdata[15:0];
          `IBS_A_TT:    tx_tone_pair_reg <= i_hwdata[15:0];
          `IBS_A_ATONE: atone_reg <= i_hwdata[11:0];
          `IBS_A_SYNC:  sync_reg <= i_hwdata[15:0];
          `IBS_A_TXD:   txd_reg <= i_hwdata[15:0];
          default: ;
        endcase
      end

      if (rd && ra == `IBS_A_RXD) begin
        status_reg[`IBS_ST_RDY] <= 1'b0;
      end
      if (rd && ra == `IBS_A_STAT) begin
        status_reg[`IBS_ST_FSYNC] <= 1'b0;
        status_reg[`IBS_ST_SYNC]  <= 1'b0;
        status_reg[`IBS_ST_DTMF]  <= 1'b0;
      end
      if (rd && ra == `IBS_A_TSTAT) begin
        tstat_reg[`IBS_TS_DTMF] <= 1'b0;
      end

      // detection runs whatever the modem is doing
      if (i_dtmf_valid && mode_reg[`IBS_IB_DTMF_RX]) begin
        tstat_reg <= {12'h000, i_dtmf_code} | (16'h0001 << `IBS_TS_DTMF);
        status_reg[`IBS_ST_DTMF] <= 1'b1;
      end

      en_d_reg <= rx_en;
      if (rx_en && !en_d_reg) begin
        search_reg <= 1'b1;
      end
      if (!rx_en) begin
        search_reg <= 1'b0;
        phased_reg <= 1'b0;
        rxslot_reg <= 1'b0;
        half_reg   <= 1'b0;
        rcnt_reg   <= 4'h0;
        slot_reg   <= 4'h0;
        sr_reg     <= 60'h0;
      end
      // a lone character left at stop goes out with an empty partner
      if (!rx_en && en_d_reg && half_reg) begin
        rxd_reg <= {ch1_reg, 8'h00};
        status_reg[`IBS_ST_RDY] <= 1'b1;
      end

      if (rx_en && bit_stb) begin
        sr_reg <= nsr;
        if (search_reg && rword == sync_reg) begin
          search_reg <= 1'b0;
          status_reg[`IBS_ST_FSYNC] <= 1'b1;
          if (raw && syn_on) begin
            status_reg[`IBS_ST_SYNC] <= 1'b1;
            rcnt_reg <= 4'h0;
          end
        end
        if (raw) begin
          // no alignment; with the sync option, words start after the match
          if (!syn_on || !search_reg) begin
            rcnt_reg <= rcnt_reg + 4'h1;
            if (rcnt_reg == `IBS_WORD_LAST) begin
              rxd_reg <= rword;
              status_reg[`IBS_ST_RDY] <= 1'b1;
            end
          end
        end else if (!phased_reg) begin
          if (phase_hit) begin
            phased_reg <= 1'b1;
            slot_reg   <= 4'h0;
            rxslot_reg <= 1'b0;
          end
        end else begin
          slot_reg <= (slot_reg == `IBS_CHAR_LAST) ? 4'h0 : slot_reg + 4'h1;
          if (slot_reg == `IBS_CHAR_LAST) begin
            rxslot_reg <= ~rxslot_reg;
            if (rxslot_reg && !half_reg) begin
              ch1_reg  <= pick;
              half_reg <= 1'b1;
            end else if (rxslot_reg) begin
              rxd_reg  <= {ch1_reg, pick};
              half_reg <= 1'b0;
              status_reg[`IBS_ST_RDY] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // tone generator; the programmed tone takes priority over dtmf
  always @(posedge i_clock) begin
    if (rst) begin
      o_tone_lo_hz      <= 12'h000;
      o_tone_hi_hz      <= 12'h000;
      o_tone_lo_on      <= 1'b0;
      o_tone_hi_on      <= 1'b0;
      o_tone_lo_cut_2db <= 1'b0;
      o_hpf_bypass      <= 1'b0;
      o_inband_mode     <= 4'h0;
      o_cfg_aux         <= 8'h00;
    end else begin
      o_inband_mode     <= mode_reg[`IBS_MC_IB];
      o_tone_lo_hz      <= tone_md ? atone_c : dtmf_lo(key);
      o_tone_hi_hz      <= dtmf_hi(key);
      o_tone_lo_on      <= tone_md | (dtmf_tx & ~(single & key[3]));
      o_tone_hi_on      <= ~tone_md & dtmf_tx & ~(single & ~key[3]);
      o_tone_lo_cut_2db <= ~tone_md & dtmf_tx & tx_tone_pair_reg[`IBS_TT_TWIST];
      // the high-pass would eat tones near its corner
      o_hpf_bypass      <= tone_md & (atone_c < `IBS_HPF_KNEE);
      o_cfg_aux         <= sel ? 8'h00 : {cfg_reg[`IBS_CF_AUX_HI], cfg_reg[`IBS_CF_AUX_LO]};
    end
  end

  // transmitter: the last loaded word repeats until the modem stops
  always @(posedge i_clock) begin
    if (rst || !tx_en) begin
      tcnt_reg     <= {CW{1'b0}};
      tx_sh_reg    <= 20'h00000;
      tx_left_reg  <= 5'h00;
      o_tx_bit     <= 1'b0;
      o_tx_on      <= 1'b0;
      o_tx_tone_hz <= 12'h000;
      o_tx_preemph <= 1'b0;
    end else begin
      o_tx_on      <= 1'b1;
      o_tx_preemph <= 1'b1;
      o_tx_tone_hz <= o_tx_bit ? `IBS_F_MARK : `IBS_F_SPACE;
      tcnt_reg     <= tick ? {CW{1'b0}} : tcnt_reg + {{(CW-1){1'b0}}, 1'b1};
      if (tick && tx_left_reg == 5'h00) begin
        o_tx_bit    <= tx_load[19];
        tx_sh_reg   <= {tx_load[18:0], 1'b0};
        tx_left_reg <= tx_len - 5'h01;
      end else if (tick) begin
        o_tx_bit    <= tx_sh_reg[19];
        tx_sh_reg   <= {tx_sh_reg[18:0], 1'b0};
        tx_left_reg <= tx_left_reg - 5'h01;
      end
    end
  end

endmodule

// [tb/ibs_modem_asserts.sv]
// concurrent checks on the ports of the inband signalling block
`timescale 1ns/1ps
module ibs_modem_asserts #(
  parameter BIT_CYCLES = 64
) (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  // register bus
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  // tone and modem outputs
  input wire logic [11:0] o_tone_lo_hz,
  input wire logic        o_hpf_bypass,
  input wire logic [3:0]  o_inband_mode,
  input wire logic        o_tx_on,
  input wire logic [11:0] o_tx_tone_hz,
  input wire logic        o_tx_preemph,
  input wire logic        o_tx_bit,
  input wire logic [7:0]  o_cfg_aux
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_addr(logic [7:0] a, logic w);
    i_hsel && i_htrans[1] && i_hready && (i_hwrite == w) && (i_haddr[7:0] == a);
  endsequence
  // address phase, then the data phase that completes the write
  sequence s_wr(logic [7:0] a);
    s_addr(a, 1'b1) ##1 i_hready;
  endsequence

  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("slave gave a non okay response");
  a_no_wait: assert property (o_hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_unmapped_zero: assert property (s_addr(8'h3c, 1'b0) |=> o_hrdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_hpf_low: assert property (o_hpf_bypass |-> o_tone_lo_hz >= 12'd288 && o_tone_lo_hz < 12'd400)
    else $error("filter bypass outside the low tone band");
  // two edges allow for the tone generator lag
  a_mode_field: assert property (s_wr(8'h00) |-> ##2 o_inband_mode == $past(i_hwdata[11:8], 2))
    else $error("inband mode differs from written field");
  a_aux_masked: assert property (s_wr(8'h04) |-> ##2
    o_cfg_aux == ($past(i_hwdata[11], 2) ? 8'h00 : {$past(i_hwdata[8:3], 2), $past(i_hwdata[1:0], 2)}))
    else $error("aux config not masked by call select");
  a_preemph_tx: assert property (o_tx_preemph == o_tx_on)
    else $error("pre-emphasis not tied to transmit");
  a_fsk_tone: assert property (o_tx_on && $past(o_tx_on) |->
    o_tx_tone_hz == ($past(o_tx_bit) ? 12'd1300 : 12'd2100))
    else $error("wrong fsk tone for transmitted bit");
  a_tone_idle: assert property (!o_tx_on && !$past(o_tx_on) |-> o_tx_tone_hz == 12'd0)
    else $error("fsk tone while transmitter off");
  a_bit_hold: assert property (o_tx_on && $changed(o_tx_bit) |=> ($stable(o_tx_bit) || !o_tx_on) [*8])
    else $error("transmitted bit too short");
endmodule

bind ibs_modem ibs_modem_asserts #(.BIT_CYCLES(BIT_CYCLES)) u_ibs_modem_asserts (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_tone_lo_hz(o_tone_lo_hz), .o_hpf_bypass(o_hpf_bypass),
  .o_inband_mode(o_inband_mode), .o_tx_on(o_tx_on), .o_tx_tone_hz(o_tx_tone_hz),
  .o_tx_preemph(o_tx_preemph), .o_tx_bit(o_tx_bit), .o_cfg_aux(o_cfg_aux));

// [tb/ibs_rx_src.sv]
// discriminator side model: sends queued words, dotting when idle
`timescale 1ns/1ps
module ibs_rx_src #(
  parameter BIT_CYCLES = 64
) (
  // clock
  input  wire logic i_clock,
  // sliced data towards the receiver
  output logic      o_rx_data
);
  int   cnt = 0;
  logic dot = 1'b0;
  logic q[$];

  initial o_rx_data = 1'b0;
  // idle dotting keeps edges coming so the receiver pll stays locked
  always @(posedge i_clock) begin
    if (cnt == BIT_CYCLES - 1) begin
      cnt <= 0;
      if (q.size() > 0) begin
        o_rx_data <= q.pop_front();
      end else begin
        o_rx_data <= dot;
        dot       <= !dot;
      end
    end else begin
      cnt <= cnt + 1;
    end
  end

  // msb goes on the line first
  task automatic push(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) q.push_back(w[i]);
  endtask

  function automatic int pending();
    return q.size();
  endfunction
endmodule

// [tb/tb.sv]
// self-checking bench for the inband signalling block
`timescale 1ns/1ps
`include "ibs_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  localparam int BC = 64;
  logic        i_clock;
  logic        i_reset_n;
  logic        hsel;
  logic        hwrite;
  logic        dtmf_valid;
  logic [1:0]  htrans;
  logic [3:0]  dtmf_code;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] r;
  logic [31:0] acc;
  logic [19:0] v;
  logic [15:0] d;
  logic [23:0] p;
  logic [11:0] e;
  logic [1:0]  e_on;
  logic [11:0] tv [6] = '{12'd100, 12'd350, 12'd399, 12'd400, 12'd2000, 12'd3500};
  int          error_cnt;
  int          check_count;
  int          seed;
  wire  [31:0] hrdata;
  wire  [11:0] lo_hz, hi_hz, tx_tone;
  wire  [3:0]  ib_mode;
  wire  [7:0]  aux;
  wire         hready, hresp, rx_data, lo_on, hi_on, cut, hpf, tx_on, preemph, tx_bit;

  ibs_modem #(.BIT_CYCLES(BC)) u_ibs_modem (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_dtmf_valid(dtmf_valid), .i_dtmf_code(dtmf_code),
    .i_rx_data(rx_data), .o_tone_lo_hz(lo_hz), .o_tone_hi_hz(hi_hz), .o_tone_lo_on(lo_on),
    .o_tone_hi_on(hi_on), .o_tone_lo_cut_2db(cut), .o_hpf_bypass(hpf), .o_inband_mode(ib_mode),
    .o_tx_on(tx_on), .o_tx_tone_hz(tx_tone), .o_tx_preemph(preemph), .o_tx_bit(tx_bit), .o_cfg_aux(aux));
  ibs_rx_src #(.BIT_CYCLES(BC)) u_ibs_rx_src (.i_clock(i_clock), .o_rx_data(rx_data));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // one single transfer; read data lands in r
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge i_clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge i_clock); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] x);
    rd(a);
    `CHK(r, x)
  endtask
  // status reads clear flags, so every value seen is collected
  task automatic poll(input logic [31:0] m);
    int n;
    acc = 32'h0;
    n = 0;
    while ((acc & m) == 32'h0 && n < 3000) begin
      rd(`IBS_A_STAT);
      acc = acc | r;
      n++;
    end
  endtask
  // samples mid-bit, first bit one period after enable
  task automatic txcap();
    repeat (BC + BC / 2) @(posedge i_clock);
    for (int i = 19; i >= 0; i--) begin
      v[i] = tx_bit;
      repeat (BC) @(posedge i_clock);
    end
  endtask

  function automatic logic [23:0] pair(input logic [3:0] k);
    logic [11:0] lo [4];
    logic [11:0] hi [4];
    logic [3:0]  rc;
    lo = '{`IBS_F_L0, `IBS_F_L1, `IBS_F_L2, `IBS_F_L3};
    hi = '{`IBS_F_H0, `IBS_F_H1, `IBS_F_H2, `IBS_F_H3};
    case (k)
      4'h0: rc = 4'hf;
      4'ha: rc = 4'hd;
      4'hb: rc = 4'hc;
      4'hc: rc = 4'he;
      4'hd, 4'he, 4'hf: rc = {k[1:0] - 2'd1, 2'd3};
      default: rc = {2'((k - 4'd1) / 4'd3), 2'((k - 4'd1) % 4'd3)};
    endcase
    return {lo[rc[3:2]], hi[rc[1:0]]};
  endfunction
  // value lsb first, then zero count msb first
  function automatic logic [9:0] sym(input logic [6:0] c);
    logic [2:0] z;
    z = 3'd0;
    for (int i = 0; i < 7; i++) z = z + {2'b0, !c[i]};
    return {c[0], c[1], c[2], c[3], c[4], c[5], c[6], z};
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_clock);
    error_cnt++;
    final_report();
  end

  initial begin
    seed = 54;
    error_cnt = 0;
    check_count = 0;
    i_reset_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, dtmf_valid, dtmf_code} = '0;
    repeat (5) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rdx(`IBS_A_SYNC, 32'h0000cb23);
    rdx(8'h3c, 32'h0);
    d = 16'($random(seed));
    wr(`IBS_A_MODE, {20'h0, d[11:8], 8'h0});
    repeat (3) @(posedge i_clock);
    `CHK(ib_mode, d[11:8])
    d = 16'($random(seed));
    for (int j = 0; j < 2; j++) begin
      wr(`IBS_A_CFG, {16'h0, d[15:12], j[0], d[10:0]});
      repeat (3) @(posedge i_clock);
      `CHK(aux, j[0] ? 8'h00 : {d[8:3], d[1:0]})
    end
    // two detections on consecutive cycles, the later one must stick
    wr(`IBS_A_MODE, 32'h100);
    d = 16'($random(seed));
    dtmf_valid <= 1'b1;
    dtmf_code  <= d[3:0];
    @(posedge i_clock);
    dtmf_code  <= d[7:4];
    @(posedge i_clock);
    dtmf_valid <= 1'b0;
    @(posedge i_clock);
    rdx(`IBS_A_TSTAT, {21'h0, 1'b1, 6'h0, d[7:4]});
    rd(`IBS_A_STAT);
    `CHK(r[12], 1'b1)
    wr(`IBS_A_MODE, 32'h200);
    for (int i = 0; i < 32; i++) begin
      wr(`IBS_A_TT, {26'h0, i[0] & ~i[4], i[4], i[3:0]});
      repeat (3) @(posedge i_clock);
      p = pair(i[3:0]);
      e_on = i[4] ? (i[3] ? 2'b01 : 2'b10) : 2'b11;
      `CHK({lo_on, hi_on}, e_on)
      `CHK(cut, i[0] & ~i[4])
      if (e_on[1]) `CHK(lo_hz, p[23:12])
      if (e_on[0]) `CHK(hi_hz, p[11:0])
    end
    wr(`IBS_A_MODE, 32'h400);
    foreach (tv[j]) begin
      wr(`IBS_A_ATONE, {20'h0, tv[j]});
      repeat (3) @(posedge i_clock);
      e = (tv[j] < 12'd288) ? 12'd288 : ((tv[j] > 12'd3000) ? 12'd3000 : tv[j]);
      `CHK(lo_hz, e)
      `CHK(hpf, e < 12'd400)
    end
    wr(`IBS_A_MODE, 32'h0);
    d = 16'($random(seed)) & 16'h7f7f;
    for (int f = 0; f < 2; f++) begin
      wr(`IBS_A_TXD, {16'h0, d});
      wr(`IBS_A_CFG, f ? 32'h800 : 32'hc00);
      wr(`IBS_A_MODE, 32'h14);
      txcap();
      `CHK(tx_on, 1'b1)
      if (f) `CHK(v, {sym(d[14:8]), sym(d[6:0])})
      else `CHK(v[19:4], d)
      wr(`IBS_A_MODE, 32'h0);
    end
    // raw receive behind the sync word
    wr(`IBS_A_CFG, 32'h8c00);
    wr(`IBS_A_MODE, 32'h4);
    d = 16'($random(seed));
    u_ibs_rx_src.push(16'hcb23);
    u_ibs_rx_src.push(d);
    poll(32'h1);
    `CHK(acc[3:0] & 4'hb, 4'hb)
    rdx(`IBS_A_RXD, {16'h0, d});
    rd(`IBS_A_STAT);
    `CHK(r[0], 1'b0)
    u_ibs_rx_src.push(16'hcb23);
    while (u_ibs_rx_src.pending() > 0) @(posedge i_clock);
    repeat (2 * BC) @(posedge i_clock);
    rd(`IBS_A_STAT);
    `CHK(r[1], 1'b0)
    wr(`IBS_A_MODE, 32'h0);
    repeat (8) @(posedge i_clock);
    wr(`IBS_A_MODE, 32'h4);
    u_ibs_rx_src.push(16'hcb23);
    poll(32'h2);
    `CHK(acc[1], 1'b1)
    wr(`IBS_A_MODE, 32'h0);
    wr(`IBS_A_SYNC, {16'h0, d});
    rdx(`IBS_A_SYNC, {16'h0, d});
    wr(`IBS_A_RST, 32'h0);
    @(posedge i_clock);
    rdx(`IBS_A_SYNC, 32'h0000cb23);
    final_report();
  end
endmodule
